// *** rtl/tws_pkg.sv ***
// package: register map, field layout, reset values and types of the port
package tws_pkg;

  // register addresses
  localparam logic [15:0] ADDR_ASYNC_MODE = 16'hFF70;
  localparam logic [15:0] ADDR_SYNC_MODE  = 16'hFF72;
  localparam logic [15:0] ADDR_BAUD_DIV   = 16'hFF73;
  localparam logic [15:0] ADDR_SHIFT_DATA = 16'hFF74;

  // reset values
  localparam logic [7:0] RST_ASYNC_MODE = 8'h00;
  localparam logic [7:0] RST_SYNC_MODE  = 8'h00;
  localparam logic [3:0] RST_DIV_SRC    = 4'h0;
  localparam logic [7:0] RST_SHIFT      = 8'h00;
  localparam logic       RST_SERIAL_OUT = 1'b1;

  // sync_mode_control field positions
  localparam int SM_ENABLE_BIT = 7;
  localparam int SM_DAP_BIT    = 3;
  localparam int SM_DIR_BIT    = 2;
  localparam int SM_CSCK_BIT   = 1;
  localparam int SM_CKP_BIT    = 0;

  // async_mode_control field positions
  localparam int AM_TXE_BIT    = 7;
  localparam int AM_RXE_BIT    = 6;
  localparam int AM_PS_HI_BIT  = 5;
  localparam int AM_PS_LO_BIT  = 4;
  localparam int AM_CL_BIT     = 3;
  localparam int AM_SL_BIT     = 2;

  // baud_divider_select source field
  localparam int         BD_SRC_LSB  = 4;
  localparam logic [3:0] SRC_DIV_MAX = 4'h6;
  localparam logic [3:0] SRC_TIMER   = 4'h7;
  localparam logic [3:0] DIV_N_BASE  = 4'h2;

  // word length of one synchronous transfer
  localparam logic [3:0] BITS_PER_WORD = 4'h8;

  // cpu request: address, strobes and write data
  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
  } tws_cpu_req_t;

  typedef struct packed {
    logic enable;
    logic dap;
    logic dir;
    logic csck;
    logic ckp;
  } tws_sync_cfg_t;

  // parity: 00 none, 01 zero bit, 10 odd, 11 even
  typedef struct packed {
    logic       txe;
    logic       rxe;
    logic [1:0] parity;
    logic       char_len;
    logic       stop_len;
  } tws_async_cfg_t;

  typedef enum logic {ST_IDLE, ST_RUN} tws_state_t;

endpackage

// *** rtl/tws_baud_div.sv ***
// baud rate divider: half-period strobe for the internal serial clock
`timescale 1ns/1ps
module tws_baud_div (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  // control
  input  wire logic       run_i,
  input  wire logic [3:0] src_sel_i,
  input  wire logic       timer_sq_i,
  // half-period strobe
  output logic            tick_o
);

  logic [7:0] cnt_q;
  logic       timer_q;
  logic       tick_q;

  // last count of a half period of fx/2^(n+3): 2^(n+2) cycles
  function automatic logic [7:0] half_last(input logic [3:0] code);
    logic [8:0] span;
    span = 9'h001 << (code + tws_pkg::DIV_N_BASE);
    half_last = 8'(span - 9'h001);
  endfunction

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      timer_q <= 1'b0;
    end else begin
      timer_q <= timer_sq_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !run_i) begin
      cnt_q  <= 8'h00;
      tick_q <= 1'b0;
    end else if (src_sel_i <= tws_pkg::SRC_DIV_MAX) begin
      if (cnt_q == half_last(src_sel_i)) begin
        cnt_q  <= 8'h00;
        tick_q <= 1'b1;
      end else begin
        cnt_q  <= cnt_q + 8'h01;
        tick_q <= 1'b0;
      end
    end else if (src_sel_i == tws_pkg::SRC_TIMER) begin
      // one toggle per timer rise halves the timer frequency
      cnt_q  <= 8'h00;
      tick_q <= timer_sq_i & ~timer_q;
    end else begin
      // prohibited codes give no clock at all
      cnt_q  <= 8'h00;
      tick_q <= 1'b0;
    end
  end

  assign tick_o = tick_q;

  sequence s_fast_run4;
    (run_i && src_sel_i == 4'h0) [*4];
  endsequence

  property p_div_fastest;
    @(posedge mclk_i) disable iff (sys_rst_i)
      (tick_o && run_i && src_sel_i == 4'h0) ##1 s_fast_run4 |-> tick_o;
  endproperty
  a_div_fastest: assert property (p_div_fastest)
    else $error("divider half period wrong for code zero");

endmodule

// *** rtl/tws_serial_port.sv ***
// three-wire synchronous serial port with its mode and divider registers
//
// Overview of operation
// - link is clock, data out, data in
// - sync mode bit 7 enables; reset clears
// - bit 3 picks output edge: fall/rise
// - bit 2 picks MSB or LSB first
// - bit 1 picks external or divider clock
// - bit 0 picks clock polarity and idle
// - async bits 7,6 enable transmit, receive
// - two-bit parity field encoding
// - bit 3 char length, bit 2 stops
// - divider codes 0-6 scale, 7 timer
// - internal clock is fx over 2^(n+3)
// - timer source gives half timer frequency
// - eight bits, full duplex, one per clock
// - shift on one edge, capture the other
// - stop after eight bits, raise done
// - data write starts only when enabled, idle
// - enabling after the write starts nothing
`timescale 1ns/1ps
module tws_serial_port (
  // clock and reset
  input  wire logic                    mclk_i,
  input  wire logic                    sys_rst_i,
  // cpu register access
  input  wire tws_pkg::tws_cpu_req_t   cpu_req_i,
  output logic [7:0]                   cpu_rdata_o,
  // timer square wave
  input  wire logic                    timer_sq_i,
  // serial link
  input  wire logic                    serial_clock_pin_i,
  output logic                         serial_clock_pin_o,
  output logic                         serial_clock_oe_n_o,
  output logic                         serial_out_pin_o,
  input  wire logic                    serial_in_pin_i,
  // status
  output logic                         sync_done_irq_o,
  output tws_pkg::tws_async_cfg_t      async_cfg_o
);

  tws_pkg::tws_sync_cfg_t  sync_q;
  tws_pkg::tws_async_cfg_t async_q;
  tws_pkg::tws_state_t     state_q;
  logic [3:0]              div_src_q;
  logic [7:0]              tx_shift_reg_q;
  logic [7:0]              rx_shift_reg_q;
  logic [7:0]              rx_buffer_reg_q;
  logic [7:0]              rdata_q;
  logic [3:0]              cyc_q;
  logic [3:0]              cap_q;
  logic [3:0]              emit_q;
  logic                    active_q;
  logic                    active_d;
  logic                    sck_pin_q;
  logic                    oe_n_q;
  logic                    so_q;
  logic                    irq_q;
  logic                    sck_s1_q;
  logic                    sck_s2_q;
  logic                    sck_s3_q;
  logic                    si_s1_q;
  logic                    si_s2_q;
  logic                    div_tick;
  logic                    running;
  logic                    ext_act;
  logic                    ext_prev;
  logic                    lead;
  logic                    trail;
  logic                    predrive;
  logic                    out_edge;
  logic                    cap_edge;
  logic                    wr_shift;
  logic                    start;
  logic                    finish;

  function automatic logic first_bit(input logic [7:0] d,
                                     input logic       lsb);
    first_bit = lsb ? d[0] : d[7];
  endfunction

  function automatic logic [7:0] shift_out(input logic [7:0] d,
                                           input logic       lsb);
    shift_out = lsb ? {1'b0, d[7:1]} : {d[6:0], 1'b0};
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] d,
                                          input logic       b,
                                          input logic       lsb);
    shift_in = lsb ? {b, d[7:1]} : {d[6:0], b};
  endfunction

  tws_baud_div u_div (
    .mclk_i     (mclk_i),
    .sys_rst_i  (sys_rst_i),
    .run_i      (running & sync_q.csck),
    .src_sel_i  (div_src_q),
    .timer_sq_i (timer_sq_i),
    .tick_o     (div_tick)
  );

  // pins from the peripheral: two stages before any use
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
      si_s1_q  <= 1'b0;
      si_s2_q  <= 1'b0;
    end else begin
      sck_s1_q <= serial_clock_pin_i;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      si_s1_q  <= serial_in_pin_i;
      si_s2_q  <= si_s1_q;
    end
  end

  always_comb begin
    running  = (state_q == tws_pkg::ST_RUN) && sync_q.enable;
    ext_act  = sync_q.ckp ? sck_s2_q : ~sck_s2_q;
    ext_prev = sync_q.ckp ? sck_s3_q : ~sck_s3_q;
    if (sync_q.csck) begin
      lead  = running & div_tick & ~active_q;
      trail = running & div_tick & active_q;
    end else begin
      lead  = running & ext_act & ~ext_prev;
      trail = running & ~ext_act & ext_prev;
    end
    // output edge is the trailing one when the first bit leads the clock
    predrive = sync_q.dap ^ sync_q.ckp;
    out_edge = predrive ? trail : lead;
    cap_edge = predrive ? lead : trail;
    wr_shift = cpu_req_i.wr && (cpu_req_i.addr == tws_pkg::ADDR_SHIFT_DATA);
    start    = wr_shift && (state_q == tws_pkg::ST_IDLE) && sync_q.enable
               && (sync_q.csck || !ext_act);
    finish   = trail && (cyc_q == tws_pkg::BITS_PER_WORD - 4'h1);
    active_d = running ? (active_q ^ (lead | trail)) : 1'b0;
  end

  // configuration registers
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sync_q    <= tws_pkg::tws_sync_cfg_t'(5'h00);
      async_q   <= tws_pkg::tws_async_cfg_t'(6'h00);
      div_src_q <= tws_pkg::RST_DIV_SRC;
    end else if (cpu_req_i.wr) begin
      case (cpu_req_i.addr)
        tws_pkg::ADDR_SYNC_MODE: begin
          sync_q.enable <= cpu_req_i.wdata[tws_pkg::SM_ENABLE_BIT];
          sync_q.dap    <= cpu_req_i.wdata[tws_pkg::SM_DAP_BIT];
          sync_q.dir    <= cpu_req_i.wdata[tws_pkg::SM_DIR_BIT];
          sync_q.csck   <= cpu_req_i.wdata[tws_pkg::SM_CSCK_BIT];
          sync_q.ckp    <= cpu_req_i.wdata[tws_pkg::SM_CKP_BIT];
        end
        tws_pkg::ADDR_ASYNC_MODE: begin
          async_q.txe      <= cpu_req_i.wdata[tws_pkg::AM_TXE_BIT];
          async_q.rxe      <= cpu_req_i.wdata[tws_pkg::AM_RXE_BIT];
          async_q.parity   <= {cpu_req_i.wdata[tws_pkg::AM_PS_HI_BIT],
                               cpu_req_i.wdata[tws_pkg::AM_PS_LO_BIT]};
          async_q.char_len <= cpu_req_i.wdata[tws_pkg::AM_CL_BIT];
          async_q.stop_len <= cpu_req_i.wdata[tws_pkg::AM_SL_BIT];
        end
        tws_pkg::ADDR_BAUD_DIV: begin
          div_src_q <= cpu_req_i.wdata[tws_pkg::BD_SRC_LSB +: 4];
        end
        default: begin
        end
      endcase
    end
  end

  // register read path, reserved bits read as zero
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rdata_q <= 8'h00;
    end else if (cpu_req_i.rd) begin
      case (cpu_req_i.addr)
        tws_pkg::ADDR_SYNC_MODE:  rdata_q <= {sync_q.enable, 3'h0,
                                              sync_q.dap, sync_q.dir,
                                              sync_q.csck, sync_q.ckp};
        tws_pkg::ADDR_ASYNC_MODE: rdata_q <= {async_q, 2'h0};
        tws_pkg::ADDR_BAUD_DIV:   rdata_q <= {div_src_q, 4'h0};
        tws_pkg::ADDR_SHIFT_DATA: rdata_q <= rx_buffer_reg_q;
        default:                  rdata_q <= 8'h00;
      endcase
    end
  end

  // transfer sequencing
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_q <= tws_pkg::ST_IDLE;
    end else begin
      case (state_q)
        tws_pkg::ST_IDLE: if (start) state_q <= tws_pkg::ST_RUN;
        tws_pkg::ST_RUN:  if (!sync_q.enable || finish) begin
          state_q <= tws_pkg::ST_IDLE;
        end
        default: state_q <= tws_pkg::ST_IDLE;
      endcase
    end
  end

  // clock cycle and bit counters
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || start) begin
      cyc_q <= 4'h0;
      cap_q <= 4'h0;
    end else begin
      if (trail) cyc_q <= cyc_q + 4'h1;
      if (cap_edge) cap_q <= cap_q + 4'h1;
    end
  end

  // internal clock generation and pin drive
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      active_q  <= 1'b0;
      sck_pin_q <= 1'b1;
      oe_n_q    <= 1'b1;
    end else begin
      active_q  <= active_d;
      sck_pin_q <= active_d ^ ~sync_q.ckp;
      oe_n_q    <= ~sync_q.csck;
    end
  end

  // transmit side: a write while busy is dropped
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      tx_shift_reg_q <= tws_pkg::RST_SHIFT;
      so_q           <= tws_pkg::RST_SERIAL_OUT;
      emit_q         <= 4'h0;
    end else if (wr_shift && state_q == tws_pkg::ST_IDLE) begin
      if (start && predrive) begin
        tx_shift_reg_q <= shift_out(cpu_req_i.wdata, sync_q.dir);
        so_q           <= first_bit(cpu_req_i.wdata, sync_q.dir);
        emit_q         <= 4'h1;
      end else begin
        tx_shift_reg_q <= cpu_req_i.wdata;
        emit_q         <= 4'h0;
      end
    end else if (out_edge && emit_q < tws_pkg::BITS_PER_WORD) begin
      // the last bit stays on the pin once the word is out
      tx_shift_reg_q <= shift_out(tx_shift_reg_q, sync_q.dir);
      so_q           <= first_bit(tx_shift_reg_q, sync_q.dir);
      emit_q         <= emit_q + 4'h1;
    end
  end

  // receive side: the buffer takes the word at the eighth capture
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rx_shift_reg_q  <= tws_pkg::RST_SHIFT;
      rx_buffer_reg_q <= tws_pkg::RST_SHIFT;
    end else if (cap_edge) begin
      rx_shift_reg_q <= shift_in(rx_shift_reg_q, si_s2_q, sync_q.dir);
      if (cap_q == tws_pkg::BITS_PER_WORD - 4'h1) begin
        rx_buffer_reg_q <= shift_in(rx_shift_reg_q, si_s2_q,
                                    sync_q.dir);
      end
    end
  end

  // disabling mid-word aborts: no done pulse for a cut transfer
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= finish;
    end
  end

  assign cpu_rdata_o         = rdata_q;
  assign serial_clock_pin_o  = sck_pin_q;
  assign serial_clock_oe_n_o = oe_n_q;
  assign serial_out_pin_o    = so_q;
  assign sync_done_irq_o     = irq_q;
  assign async_cfg_o         = async_q;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_idle2;
    (state_q == tws_pkg::ST_IDLE && $stable(sync_q.ckp)) [*2];
  endsequence

  sequence s_started;
    state_q == tws_pkg::ST_RUN && cyc_q == 4'h0 && cap_q == 4'h0;
  endsequence

  property p_reset_regs;
    $fell(sys_rst_i) |-> sync_q == 5'h00 && async_q == 6'h00
                         && div_src_q == 4'h0;
  endproperty
  a_reset_regs: assert property (p_reset_regs)
    else $error("mode registers not cleared by reset");

  property p_async_bits;
    cpu_req_i.wr && cpu_req_i.addr == tws_pkg::ADDR_ASYNC_MODE
      |=> async_cfg_o.txe == $past(cpu_req_i.wdata[7])
          && async_cfg_o.rxe == $past(cpu_req_i.wdata[6]);
  endproperty
  a_async_bits: assert property (p_async_bits)
    else $error("async enable bits not stored");

  property p_no_start;
    wr_shift && !sync_q.enable |=> state_q == tws_pkg::ST_IDLE;
  endproperty
  a_no_start: assert property (p_no_start)
    else $error("transfer started while disabled");

  property p_start;
    start |=> s_started;
  endproperty
  a_start: assert property (p_start)
    else $error("enabled idle write did not start a transfer");

  property p_done_pulse;
    sync_done_irq_o |-> state_q == tws_pkg::ST_IDLE ##1 !sync_done_irq_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done request not a single pulse at idle");

  property p_done_count;
    sync_done_irq_o |-> cap_q == 4'h8 && emit_q == 4'h8;
  endproperty
  a_done_count: assert property (p_done_count)
    else $error("done raised without eight bits each way");

  property p_idle_level;
    s_idle2 ##0 sync_q.csck |-> serial_clock_pin_o == ~sync_q.ckp;
  endproperty
  a_idle_level: assert property (p_idle_level)
    else $error("serial clock not at idle level");

  property p_first_bit;
    start && predrive |=> serial_out_pin_o == ($past(sync_q.dir)
      ? $past(cpu_req_i.wdata[0]) : $past(cpu_req_i.wdata[7]));
  endproperty
  a_first_bit: assert property (p_first_bit)
    else $error("wrong first bit driven");

  property p_oe;
    sync_q.csck |=> !serial_clock_oe_n_o;
  endproperty
  a_oe: assert property (p_oe)
    else $error("clock pin not driven with internal source");

  property p_abort_hold;
    state_q == tws_pkg::ST_RUN && !sync_q.enable && cap_q < 4'h8
      |=> $stable(rx_buffer_reg_q) && !sync_done_irq_o;
  endproperty
  a_abort_hold: assert property (p_abort_hold)
    else $error("aborted transfer changed buffer or raised done");

endmodule

// *** tb/tws_peer_model.sv ***
// far-side serial peripheral model: shifts a word in and out
`timescale 1ns/1ps
module tws_peer_model (
  // link
  input  wire logic sck_i,
  input  wire logic sdo_i,
  output logic      sck_o,
  output logic      sdi_o
);
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic       dap_q;
  logic       lsb_q;
  int         n_out;
  int         n_cap;

  initial begin
    sck_o = 1'b1;
    sdi_o = 1'b0;
    dap_q = 1'b0;
    lsb_q = 1'b0;
    n_out = 8;
    n_cap = 8;
  end

  function automatic int idx(input int i);
    return lsb_q ? i : 7 - i;
  endfunction

  // arm one word; own idle level settles before counting edges
  task automatic load(input logic [7:0] tx, input logic dap, ckp, lsb);
    sck_o = ~ckp;
    #1;
    tx_q = tx;
    dap_q = dap;
    lsb_q = lsb;
    rx_q = 8'h00;
    n_cap = 0;
    n_out = 0;
    // leading edge captures: first bit must already stand
    if (dap != ckp) begin
      sdi_o = tx[idx(0)];
      n_out = 1;
    end
  endtask

  // clock source role: eight cycles, back to idle
  task automatic run(input int half_ns);
    repeat (16) begin
      #(half_ns) sck_o = ~sck_o;
    end
  endtask

  task automatic out_edge();
    if (n_out < 8) begin
      sdi_o = tx_q[idx(n_out)];
      n_out++;
    end else begin
      sdi_o = ~sdi_o; // word over: no stale bit on the line
    end
  endtask

  task automatic cap_edge();
    if (n_cap < 8) begin
      rx_q[idx(n_cap)] = sdo_i;
      n_cap++;
    end
  endtask

  always @(negedge sck_i) begin
    if (!dap_q) out_edge(); else cap_edge();
  end

  always @(posedge sck_i) begin
    if (dap_q) out_edge(); else cap_edge();
  end
endmodule

// *** tb/tb_top.sv ***
// self-checking bench: registers, clock rates, word transfers, refusals
`timescale 1ns/1ps
module tb_top;
  logic                    mclk_i;
  logic                    sys_rst_i;
  tws_pkg::tws_cpu_req_t   cpu_req_i;
  logic [7:0]              cpu_rdata_o;
  logic                    timer_sq_i;
  logic                    sck_drv;
  logic                    sck_oe_n;
  logic                    serial_out_pin_o;
  logic                    sync_done_irq_o;
  tws_pkg::tws_async_cfg_t async_cfg_o;
  logic                    peer_sck;
  logic                    peer_sdi;
  logic                    sck_line;
  logic                    got;
  int                      fails;
  int                      n_compared;
  int                      tcnt;

  assign sck_line = sck_oe_n ? peer_sck : sck_drv;

  tws_serial_port uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .cpu_req_i(cpu_req_i), .cpu_rdata_o(cpu_rdata_o),
    .timer_sq_i(timer_sq_i), .serial_clock_pin_i(sck_line),
    .serial_clock_pin_o(sck_drv), .serial_clock_oe_n_o(sck_oe_n),
    .serial_out_pin_o(serial_out_pin_o), .serial_in_pin_i(peer_sdi),
    .sync_done_irq_o(sync_done_irq_o), .async_cfg_o(async_cfg_o));

  tws_peer_model peer (.sck_i(sck_line), .sdo_i(serial_out_pin_o),
    .sck_o(peer_sck), .sdi_o(peer_sdi));

  initial mclk_i = 1'b0;
  always #50 mclk_i = ~mclk_i;

  // timer square wave, 6-cycle period
  always @(posedge mclk_i) begin
    tcnt <= (tcnt == 2) ? 0 : tcnt + 1;
    if (tcnt == 2) timer_sq_i <= ~timer_sq_i;
  end

  task automatic test_done();
    if (fails == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    cpu_req_i <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge mclk_i);
    cpu_req_i.wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e, string nm);
    @(posedge mclk_i);
    cpu_req_i <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge mclk_i);
    cpu_req_i.rd <= 1'b0;
    @(posedge mclk_i);
    #1;
    chk(nm, cpu_rdata_o, e);
  endtask

  task automatic wait_done(input logic need, output logic g);
    g = 1'b0;
    for (int i = 0; i < 400 && !g; i++) begin
      @(posedge mclk_i);
      #1;
      if (sync_done_irq_o === 1'b1) g = 1'b1;
    end
    if (g) begin
      @(posedge mclk_i);
      #1;
      chk("irq pulse", {7'h00, sync_done_irq_o}, 8'h00);
    end
    if (need && !g) begin
      fails++;
      $display("[ERR] irq exp 1 seen 0");
      test_done();
    end
  endtask

  // rise-to-rise period of the driven clock, in system cycles
  task automatic meas(input int per);
    int n;
    int t0;
    logic prev;
    n = 0;
    t0 = 0;
    prev = sck_drv;
    for (int c = 0; c < 300 && n < 2; c++) begin
      @(posedge mclk_i);
      #1;
      if (sck_drv === 1'b1 && prev === 1'b0) begin
        n++;
        if (n == 1) t0 = c;
        else chk("period", 8'(c - t0), 8'(per));
      end
      prev = sck_drv;
    end
    if (n < 2) chk("rises", 8'(n), 8'h02);
  endtask

  task automatic xfer(input logic [7:0] m, tx, rx, input int per);
    logic g;
    wr(tws_pkg::ADDR_SYNC_MODE, m);
    repeat (4) @(posedge mclk_i);
    #1;
    chk("clk oe_n", {7'h00, sck_oe_n}, {7'h00, ~m[1]});
    if (m[1]) chk("idle", {7'h00, sck_line}, {7'h00, ~m[0]});
    peer.load(rx, m[3], m[0], m[2]);
    // new idle level must clear the pin synchroniser before the write
    repeat (3) @(posedge mclk_i);
    wr(tws_pkg::ADDR_SHIFT_DATA, tx);
    fork
      if (!m[1]) peer.run(800);
      wait_done(1'b1, g);
      if (per != 0) meas(per);
    join
    chk("peer rx", peer.rx_q, tx);
    chk("edges", 8'(peer.n_cap), 8'h08);
    chk("hold", {7'h00, serial_out_pin_o},
        {7'h00, m[2] ? tx[7] : tx[0]});
    rd(tws_pkg::ADDR_SHIFT_DATA, rx, "rx buf");
  endtask

  task automatic t_reset();
    chk("out rst", {7'h00, serial_out_pin_o}, 8'h01);
    chk("oe rst", {7'h00, sck_oe_n}, 8'h01);
    chk("cfg rst", {2'b00, async_cfg_o}, 8'h00);
    rd(tws_pkg::ADDR_SYNC_MODE, 8'h00, "sync rst");
    rd(tws_pkg::ADDR_ASYNC_MODE, 8'h00, "async rst");
    rd(tws_pkg::ADDR_BAUD_DIV, 8'h00, "div rst");
  endtask

  task automatic t_regs();
    for (int p = 0; p < 4; p++) begin
      wr(tws_pkg::ADDR_ASYNC_MODE, {2'b11, 2'(p), 2'(p), 2'b00});
      #1;
      chk("async cfg", {2'b00, async_cfg_o},
          {4'h3, 2'(p), 2'(p)});
      rd(tws_pkg::ADDR_ASYNC_MODE, {2'b11, 2'(p), 2'(p), 2'b00},
         "async");
    end
    wr(tws_pkg::ADDR_ASYNC_MODE, 8'h00);
    wr(16'hFF71, 8'hFF);
    rd(16'hFF71, 8'h00, "unmapped");
    wr(tws_pkg::ADDR_SYNC_MODE, 8'h0F);
    rd(tws_pkg::ADDR_SYNC_MODE, 8'h0F, "sync");
    for (int c = 0; c < 8; c++) begin
      wr(tws_pkg::ADDR_BAUD_DIV, {4'(c), 4'h0});
      rd(tws_pkg::ADDR_BAUD_DIV, {4'(c), 4'h0}, "div");
    end
  endtask

  task automatic t_refuse();
    wr(tws_pkg::ADDR_BAUD_DIV, 8'h10);
    wr(tws_pkg::ADDR_SYNC_MODE, 8'h02);
    wr(tws_pkg::ADDR_SHIFT_DATA, 8'h3C);
    wr(tws_pkg::ADDR_SYNC_MODE, 8'h82);
    wait_done(1'b0, got);
    chk("no start", {7'h00, got}, 8'h00);
    peer.load(8'h5A, 1'b0, 1'b0, 1'b0);
    wr(tws_pkg::ADDR_SHIFT_DATA, 8'hC3);
    repeat (20) @(posedge mclk_i);
    wr(tws_pkg::ADDR_SHIFT_DATA, 8'h00);
    wait_done(1'b1, got);
    chk("busy drop", peer.rx_q, 8'hC3);
    peer.load(8'h66, 1'b0, 1'b0, 1'b0);
    wr(tws_pkg::ADDR_SHIFT_DATA, 8'h99);
    repeat (40) @(posedge mclk_i);
    wr(tws_pkg::ADDR_SYNC_MODE, 8'h02);
    wait_done(1'b0, got);
    chk("abort irq", {7'h00, got}, 8'h00);
    wr(tws_pkg::ADDR_SHIFT_DATA, 8'hFF);
    rd(tws_pkg::ADDR_SHIFT_DATA, 8'h5A, "abort buf");
  endtask

  // no wait can outlast this bound
  initial begin
    #2000000;
    fails++;
    test_done();
  end

  initial begin
    fails = 0;
    n_compared = 0;
    tcnt = 0;
    timer_sq_i = 1'b0;
    sys_rst_i = 1'b1;
    cpu_req_i = '0;
    repeat (8) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    t_reset();
    t_regs();
    wr(tws_pkg::ADDR_BAUD_DIV, 8'h00);
    xfer(8'h82, 8'hA5, 8'h3C, 8);
    wr(tws_pkg::ADDR_BAUD_DIV, 8'h70);
    xfer(8'h82, 8'h96, 8'hE1, 12);
    wr(tws_pkg::ADDR_BAUD_DIV, 8'h10);
    for (int m = 0; m < 8; m++) begin
      xfer({4'h8, m[2], m[1], 1'b1, m[0]}, 8'(37 * m + 11),
           8'(~(53 * m)), 16);
    end
    for (int m = 0; m < 8; m++) begin
      xfer({4'h8, m[2], m[1], 1'b0, m[0]}, 8'(29 * m + 5),
           8'(91 * m + 3), 0);
    end
    t_refuse();
    test_done();
  end
endmodule
